//--- pkg/swdc_pkg.sv
package swdc_pkg;
  // ==========================================================
  // Register map
  localparam logic [6:0] SWDC_ADDR_DISCHARGE = 7'h36;
  localparam logic [6:0] SWDC_ADDR_WAKE_MASK = 7'h40;
  localparam logic [6:0] SWDC_ADDR_PRESLEEP = 7'h41;
  localparam logic [6:0] SWDC_ADDR_POLL_CFG = 7'h42;
  // ==========================================================
  // Field positions
  localparam int SWDC_DIS_EN_LSB = 9;
  localparam int SWDC_DIS_EN_MSB = 12;
  localparam int SWDC_DIS_TIM_LSB = 0;
  localparam int SWDC_DIS_TIM_MSB = 3;
  localparam int SWDC_CHAN_MSB = 14;
  localparam int SWDC_PB_LSB = 6;
  localparam int SWDC_PB_MSB = 7;
  localparam int SWDC_PT_LSB = 4;
  localparam int SWDC_PT_MSB = 5;
  localparam int SWDC_AC_LSB = 0;
  localparam int SWDC_AC_MSB = 3;
  // ==========================================================
  // Reset values
  localparam logic [3:0] SWDC_DIS_EN_RST = 4'h0;
  localparam logic [3:0] SWDC_DIS_TIM_RST = 4'h0;
  localparam logic [14:0] SWDC_CHAN_RST = 15'h0000;
  localparam logic [1:0] SWDC_PB_RST = 2'h0;
  localparam logic [1:0] SWDC_PT_RST = 2'h1;
  localparam logic [3:0] SWDC_AC_RST = 4'h0;
  // ==========================================================
  // Sleep entry codes, in order
  localparam logic [3:0] SWDC_CODE_FIRST = 4'h5;
  localparam logic [3:0] SWDC_CODE_SECOND = 4'hA;
  localparam logic [3:0] SWDC_CODE_THIRD = 4'hC;
  // ==========================================================
  // Timing
  localparam int SWDC_CLK_PERIOD_NS = 20;
  localparam int SWDC_MS_NS = 1000000;
  localparam int SWDC_MS_CYCLES = SWDC_MS_NS / SWDC_CLK_PERIOD_NS;
  // Sequencer states
  typedef enum logic [1:0] {SWDC_SEQ_IDLE, SWDC_SEQ_GOT1, SWDC_SEQ_GOT2} swdc_seq_e;
endpackage : swdc_pkg

//--- hdl/swdc_seq.sv
`timescale 1ns/100ps
// ==========================================================
// Sleep entry code sequencer
module swdc_seq
  import swdc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic code_wr,
  input wire logic [3:0] code,
  output logic sleep_req_q
);
  swdc_seq_e state_q, state_d;
  logic sleep_req_d;

  // Any wrong code drops the partial sequence; a first code restarts it
  always_comb begin
    state_d = state_q;
    sleep_req_d = 1'b0;
    if (code_wr) begin
      case (state_q)
        SWDC_SEQ_IDLE: state_d = (code == SWDC_CODE_FIRST) ? SWDC_SEQ_GOT1 : SWDC_SEQ_IDLE;
        SWDC_SEQ_GOT1: begin
          if (code == SWDC_CODE_SECOND) begin
            state_d = SWDC_SEQ_GOT2;
          end else begin
            state_d = (code == SWDC_CODE_FIRST) ? SWDC_SEQ_GOT1 : SWDC_SEQ_IDLE;
          end
        end
        SWDC_SEQ_GOT2: begin
          if (code == SWDC_CODE_THIRD) begin
            state_d = SWDC_SEQ_IDLE;
            sleep_req_d = 1'b1;
          end else begin
            state_d = (code == SWDC_CODE_FIRST) ? SWDC_SEQ_GOT1 : SWDC_SEQ_IDLE;
          end
        end
        default: state_d = SWDC_SEQ_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= SWDC_SEQ_IDLE;
      sleep_req_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sleep_req_q <= sleep_req_d;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  AST_SEQ_ORDER: assert property (
    code_wr && code == SWDC_CODE_FIRST ##1 code_wr && code == SWDC_CODE_SECOND
    ##1 code_wr && code == SWDC_CODE_THIRD |=> sleep_req_q)
    else $error("ordered codes did not request sleep");
  AST_SEQ_BAD_RESTART: assert property (
    state_q == SWDC_SEQ_GOT2 && code_wr && code != SWDC_CODE_THIRD
    && code != SWDC_CODE_FIRST |=> state_q == SWDC_SEQ_IDLE && !sleep_req_q)
    else $error("wrong code did not discard sequence");
  AST_SEQ_NEEDS_THIRD: assert property (
    $rose(sleep_req_q) |-> $past(code) == SWDC_CODE_THIRD && $past(state_q) == SWDC_SEQ_GOT2)
    else $error("sleep requested without full sequence");
  COV_SEQ_SLEEP: cover property (sleep_req_q);
endmodule : swdc_seq

//--- hdl/swdc_regs.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Four discharge enables at bits 12:9, channels 9 to 12, clear on reset.
// - Discharge duration field bits 3:0 gives n milliseconds, resets to zero.
// - One wake source select bit per channel in bits 14:0.
// - Wake source selects all reset to zero.
// - Pre-sleep expected level bit per channel in bits 14:0, reset zero.
// - Blank time bits 7:6 reset 00; poll period bits 5:4 reset 01.
// - Sleep entered only after codes 0101, 1010, 1100 in successive poll config writes; other register writes between them are ignored.
// - On polling exit latch each channel differing from pre-sleep level, mask ignored.
module swdc_regs
  import swdc_pkg::*;
#(
  parameter int MS_CYCLES = SWDC_MS_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [6:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata_q,
  output logic rd_valid_q,
  input wire logic discharge_start,
  output logic [3:0] discharge_on_q,
  output logic [14:0] wake_source_select_q,
  output logic [1:0] poll_blank_time_q,
  output logic [1:0] poll_period_q,
  output logic sleep_req_q,
  input wire logic [14:0] chan_level,
  input wire logic poll_exit,
  input wire logic latch_clr,
  output logic [14:0] level_change_latch_q
);
  // ==========================================================
  // Storage
  logic [3:0] dis_en_q;
  logic [3:0] dis_tim_q;
  logic [14:0] presleep_q;
  logic [3:0] code_q;
  logic [3:0] ms_left_q, ms_left_d;
  logic [31:0] cyc_q, cyc_d;

  // Address decode
  wire sel_dis = addr == SWDC_ADDR_DISCHARGE;
  wire sel_wak = addr == SWDC_ADDR_WAKE_MASK;
  wire sel_pre = addr == SWDC_ADDR_PRESLEEP;
  wire sel_cfg = addr == SWDC_ADDR_POLL_CFG;
  wire code_wr = wr_en && sel_cfg;

  // Read mux; parity and reserved bits read zero, unmapped reads zero
  wire [15:0] rd_mux =
    sel_dis ? {3'h0, dis_en_q, 5'h00, dis_tim_q} :
    sel_wak ? {1'h0, wake_source_select_q} :
    sel_pre ? {1'h0, presleep_q} :
    sel_cfg ? {8'h00, poll_blank_time_q, poll_period_q, code_q} : 16'h0000;

  // Configuration writes
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dis_en_q <= SWDC_DIS_EN_RST;
      dis_tim_q <= SWDC_DIS_TIM_RST;
      wake_source_select_q <= SWDC_CHAN_RST;
      presleep_q <= SWDC_CHAN_RST;
      poll_blank_time_q <= SWDC_PB_RST;
      poll_period_q <= SWDC_PT_RST;
      code_q <= SWDC_AC_RST;
    end else if (wr_en) begin
      if (sel_dis) begin
        dis_en_q <= wdata[SWDC_DIS_EN_MSB:SWDC_DIS_EN_LSB];
        dis_tim_q <= wdata[SWDC_DIS_TIM_MSB:SWDC_DIS_TIM_LSB];
      end
      if (sel_wak) begin
        wake_source_select_q <= wdata[SWDC_CHAN_MSB:0];
      end
      if (sel_pre) begin
        presleep_q <= wdata[SWDC_CHAN_MSB:0];
      end
      if (sel_cfg) begin
        poll_blank_time_q <= wdata[SWDC_PB_MSB:SWDC_PB_LSB];
        poll_period_q <= wdata[SWDC_PT_MSB:SWDC_PT_LSB];
        code_q <= wdata[SWDC_AC_MSB:SWDC_AC_LSB];
      end
    end
  end

  // Read answer one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_q <= 16'h0000;
      rd_valid_q <= 1'b0;
    end else begin
      rdata_q <= rd_en ? rd_mux : rdata_q;
      rd_valid_q <= rd_en;
    end
  end

  // ==========================================================
  // Discharge timer: whole milliseconds counted down.
  // A start while running restarts from the current duration.
  wire tick = cyc_q == MS_CYCLES - 1;
  always_comb begin
    ms_left_d = ms_left_q;
    cyc_d = cyc_q;
    if (discharge_start) begin
      ms_left_d = dis_tim_q;
      cyc_d = 32'h0;
    end else if (ms_left_q != 4'h0) begin
      cyc_d = tick ? 32'h0 : cyc_q + 32'h1;
      ms_left_d = tick ? ms_left_q - 4'h1 : ms_left_q;
    end
  end
  wire [3:0] dis_on_d = (ms_left_d != 4'h0) ? dis_en_q : 4'h0;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ms_left_q <= 4'h0;
      cyc_q <= 32'h0;
      discharge_on_q <= 4'h0;
    end else begin
      ms_left_q <= ms_left_d;
      cyc_q <= cyc_d;
      discharge_on_q <= dis_on_d;
    end
  end

  // ==========================================================
  // Level change latch; a new change beats a clear in the same cycle
  wire [14:0] diff = chan_level ^ presleep_q;
  wire [14:0] latch_set = poll_exit ? diff : 15'h0000;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      level_change_latch_q <= SWDC_CHAN_RST;
    end else begin
      level_change_latch_q <= (latch_clr ? 15'h0000 : level_change_latch_q) | latch_set;
    end
  end

  // Sleep entry sequence
  swdc_seq u_seq (
    .ref_clk(ref_clk),
    .srst(srst),
    .code_wr(code_wr),
    .code(wdata[SWDC_AC_MSB:SWDC_AC_LSB]),
    .sleep_req_q(sleep_req_q)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  AST_DIS_EN_MAP: assert property (
    wr_en && sel_dis ##1 discharge_start && dis_tim_q != 4'h0 |=> discharge_on_q == dis_en_q)
    else $error("discharge enables not applied");
  AST_DIS_LEN: assert property (
    discharge_start && !wr_en |=> ms_left_q == $past(dis_tim_q))
    else $error("discharge duration not loaded");
  AST_WAK_WRITE: assert property (
    wr_en && sel_wak |=> wake_source_select_q == $past(wdata[14:0]))
    else $error("wake mask not written");
  // Reset checks must not be switched off by the reset they check
  AST_WAK_RESET: assert property (@(posedge ref_clk) disable iff (1'b0)
    srst |=> wake_source_select_q == 15'h0000)
    else $error("wake mask not cleared by reset");
  AST_PRE_READ: assert property (
    wr_en && sel_pre ##1 rd_en && sel_pre && !wr_en |=> rdata_q == {1'b0, $past(wdata[14:0], 2)})
    else $error("presleep level readback wrong");
  AST_POLL_RESET: assert property (@(posedge ref_clk) disable iff (1'b0)
    srst |=> poll_period_q == 2'h1 && poll_blank_time_q == 2'h0)
    else $error("poll fields reset wrong");
  AST_LATCH_SET: assert property (
    poll_exit |=> (level_change_latch_q & $past(diff)) == $past(diff))
    else $error("level change not latched");
  AST_NO_SLEEP_SINGLE: assert property (
    !code_wr [*3] |=> !sleep_req_q)
    else $error("sleep without code writes");
  AST_BAD_CODE: assert property (
    code_wr && wdata[3:0] != SWDC_CODE_SECOND ##1 code_wr && wdata[3:0] == SWDC_CODE_THIRD
    |=> !sleep_req_q)
    else $error("broken sequence requested sleep");

  COV_DISCHARGE: cover property (discharge_start ##1 discharge_on_q != 4'h0);
  COV_LATCH: cover property (poll_exit && diff != 15'h0000);
  COV_CLR_SET: cover property (latch_clr && poll_exit && diff != 15'h0000);
endmodule : swdc_regs

//--- verif/swdc_host.sv
`timescale 1ns/100ps
// ==========================================================
// Host side of the register frame port
module swdc_host (
  input wire logic ref_clk,
  output logic wr_en,
  output logic rd_en,
  output logic [6:0] addr,
  output logic [15:0] wdata
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 7'h00;
    wdata = 16'h0000;
  end
  // Strobe stays up across back-to-back frames
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    {wr_en, rd_en, addr, wdata} = {2'b10, a, d};
  endtask : wr
  task automatic rd(input logic [6:0] a);
    @(negedge ref_clk);
    {wr_en, rd_en, addr} = {2'b01, a};
  endtask : rd
  // Released lines flip so stale values cannot pass
  task automatic idle();
    @(negedge ref_clk);
    {wr_en, rd_en, addr, wdata} = {2'b00, ~addr, ~wdata};
  endtask : idle
endmodule : swdc_host

//--- verif/tb.sv
`timescale 1ns/100ps
// ==========================================================
// Register bank bench
module tb;
  import swdc_pkg::*;
  localparam int MSC = 10;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic discharge_start = 1'b0;
  logic poll_exit = 1'b0;
  logic latch_clr = 1'b0;
  logic [14:0] chan_level = 15'h0000;
  logic wr_en, rd_en, rd_valid_q, sleep_req_q;
  logic [6:0] addr;
  logic [15:0] wdata, rdata_q, d;
  logic [3:0] discharge_on_q;
  logic [14:0] wake_source_select_q, level_change_latch_q;
  logic [1:0] poll_blank_time_q, poll_period_q;
  logic [31:0] seed = 32'h78CB;
  logic [15:0] exp_q[$];
  logic [15:0] last[4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0010};
  logic [6:0] amap[4] = '{7'h36, 7'h40, 7'h41, 7'h42};
  logic [15:0] mmap[4] = '{16'h1E0F, 16'h7FFF, 16'h7FFF, 16'h00FF};
  logic [3:0] codes[17] = '{4'h5, 4'hA, 4'hC, 4'h5, 4'h5, 4'hA, 4'hC, 4'h5, 4'hA,
    4'h3, 4'hC, 4'hA, 4'hC, 4'h5, 4'hA, 4'hA, 4'hC};
  int err_total = 0;
  int cmp_count = 0;
  int sleep_n = 0;
  int cyc = 0;
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  swdc_host host_u (.ref_clk(ref_clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata));
  swdc_regs #(.MS_CYCLES(MSC)) dut_u (.ref_clk(ref_clk), .srst(srst), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata_q(rdata_q), .rd_valid_q(rd_valid_q),
    .discharge_start(discharge_start), .discharge_on_q(discharge_on_q),
    .wake_source_select_q(wake_source_select_q), .poll_blank_time_q(poll_blank_time_q),
    .poll_period_q(poll_period_q), .sleep_req_q(sleep_req_q), .chan_level(chan_level),
    .poll_exit(poll_exit), .latch_clr(latch_clr),
    .level_change_latch_q(level_change_latch_q));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic finish_test();
    if (err_total == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // Reads back all four registers plus one unmapped place
  task automatic readall();
    for (int k = 0; k < 4; k++) begin
      exp_q.push_back(last[k]);
      host_u.rd(amap[k]);
    end
    exp_q.push_back(16'h0000);
    host_u.rd(7'h37);
    host_u.idle();
  endtask : readall
  // Watcher: read answers pop the oldest note; sleep pulses are counted per cycle
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 4000) begin
      err_total++;
      finish_test();
    end
  end
  // Outputs are looked at mid-cycle, where they have settled
  always @(negedge ref_clk) begin
    if (rd_valid_q === 1'b1) begin
      if (exp_q.size() == 0) chk(rdata_q, 16'hDEAD);
      else chk(rdata_q, exp_q.pop_front());
    end
    if (sleep_req_q === 1'b1) sleep_n++;
  end
  initial begin
    repeat (4) @(negedge ref_clk);
    srst = 1'b0;
    chk({12'h000, poll_blank_time_q, poll_period_q}, 16'h0001);
    readall();
    // Random data on every register, parity bit included
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      d = seed[15:0];
      if (i % 4 == 3) d[3:0] = 4'h0;
      host_u.wr(amap[i % 4], d);
      host_u.idle();
      last[i % 4] = d & mmap[i % 4];
      if (i % 4 == 1) chk({1'b0, wake_source_select_q}, {1'b0, d[14:0]});
      if (i % 4 == 3) chk({12'h000, poll_blank_time_q, poll_period_q}, {12'h000, d[7:4]});
    end
    host_u.wr(7'h37, 16'hFFFF);
    readall();
    // Code streams: two complete ordered runs, then a third split by a wake mask write, give three sleeps
    for (int i = 0; i < 17; i++) host_u.wr(7'h42, {12'h001, codes[i]});
    host_u.wr(7'h42, 16'h0015);
    host_u.wr(7'h40, 16'h0000);
    last[1] = 16'h0000;
    host_u.wr(7'h42, 16'h001A);
    host_u.wr(7'h42, 16'h001C);
    host_u.idle();
    repeat (3) @(negedge ref_clk);
    chk(16'(sleep_n), 16'd3);
    // Discharge of 2 ms on channels 10 and 12, then duration zero
    host_u.wr(7'h36, 16'h1402);
    host_u.idle();
    discharge_start = 1'b1;
    @(negedge ref_clk);
    discharge_start = 1'b0;
    chk({12'h000, discharge_on_q}, 16'h000A);
    repeat (2 * MSC - 1) @(negedge ref_clk);
    chk({12'h000, discharge_on_q}, 16'h000A);
    @(negedge ref_clk);
    chk({12'h000, discharge_on_q}, 16'h0000);
    host_u.wr(7'h36, 16'h1E00);
    host_u.idle();
    discharge_start = 1'b1;
    @(negedge ref_clk);
    discharge_start = 1'b0;
    chk({12'h000, discharge_on_q}, 16'h0000);
    // Level change latch ignores the wake mask
    seed = xs(seed);
    host_u.wr(7'h41, seed[15:0]);
    exp_q.push_back(seed[15:0] & 16'h7FFF);
    host_u.rd(7'h41);
    host_u.idle();
    chan_level = seed[30:16];
    poll_exit = 1'b1;
    @(negedge ref_clk);
    poll_exit = 1'b0;
    chk({1'b0, level_change_latch_q}, {1'b0, seed[14:0] ^ seed[30:16]});
    latch_clr = 1'b1;
    @(negedge ref_clk);
    latch_clr = 1'b0;
    chk({1'b0, level_change_latch_q}, 16'h0000);
    last[0] = 16'h1E00;
    last[2] = seed[15:0] & 16'h7FFF;
    last[3] = 16'h001C;
    readall();
    repeat (4) @(negedge ref_clk);
    if (exp_q.size() != 0) chk(16'(exp_q.size()), 16'h0000);
    finish_test();
  end
endmodule : tb
